// >>> design/slc_strap_latch.v
// Strap latch and configuration block of the transceiver: catches the
// board straps once after chip reset, serves them and a few controls to
// software, matches management addresses and drives wake and clock pins.
// Assumes all inputs synchronous to core_clk and straps stable at release.
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "slc_map.vh"

module slc_strap_latch (
    // Clock and reset
    input  wire        core_clk,
    input  wire        nrst,

    // Board straps
    input  wire [2:0]  mgmt_addr_strap,
    input  wire        broadcast_addr_strap,
    input  wire [3:0]  mode_strap,
    input  wire        refclk_out_strap,
    input  wire        lamp_style_strap,

    // Register port
    input  wire [3:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,

    // Management address check
    input  wire        mgmt_req_valid,
    input  wire [4:0]  mgmt_req_addr,
    output reg         mgmt_addr_hit,

    // Wake detector and lamp drivers from the core
    input  wire        wol_event,
    input  wire        lamp_a_in,
    input  wire        lamp_b_in,

    // Clock sources sampled as levels
    input  wire        refclk_local,
    input  wire        refclk_rx,

    // Pins
    output reg         lamp_out_a,
    output reg         lamp_out_b,
    output reg         wake_event_n,
    output reg         refclk_out_pin,

    // Configuration to the rest of the transceiver
    output reg  [4:0]  mgmt_addr,
    output reg  [3:0]  op_mode,
    output reg         lamp_individual,
    output reg         mode_mii,
    output reg         mode_nand_tree,
    output reg         mode_power_down,
    output reg         mode_reserved,
    output reg         straps_valid,

    // Interrupt
    output reg         irq
);

    // Latched straps
    reg                      captured;
    reg [2:0]                addr_lat;
    reg                      bcast_lat;
    reg [3:0]                mode_lat;
    reg                      refclk_lat;
    reg                      lamp_lat;

    // Software state
    reg [`SLC_CTRL_W-1:0]    ctrl;
    reg [`SLC_EV_W-1:0]      status;
    reg [`SLC_EV_W-1:0]      enable;

    // Combinational helpers
    reg [`SLC_EV_W-1:0]      events;
    reg [`SLC_EV_W-1:0]      next_status;
    reg [15:0]               next_rdata;
    reg                      hit_own;
    reg                      hit_zero;
    reg                      wake_a;
    reg                      wake_b;
    reg                      clk_src;

    // Next register values
    reg [`SLC_CTRL_W-1:0]    next_ctrl;
    reg [`SLC_EV_W-1:0]      next_enable;
    reg                      next_lamp_a;
    reg                      next_lamp_b;
    reg                      next_wake_n;
    reg                      next_refclk;
    reg                      next_mii;
    reg                      next_nand;
    reg                      next_pdown;
    reg                      next_reserved;

    wire [4:0] own_addr = {`SLC_ADDR_HI, addr_lat};

    // Same address compare used for own address and for address 0
    function addr_match;
        input [4:0] req;
        input [4:0] target;
        begin
            addr_match = (req == target);
        end
    endfunction

    // Interface modes, shared by the decode output and the reserved test
    function mode_is_mii;
        input [3:0] m;
        begin
            mode_is_mii = (m == `SLC_MODE_MII) || (m == `SLC_MODE_MII_W1) ||
                          (m == `SLC_MODE_MII_W2);
        end
    endfunction

    // Reserved and unlisted codes fall out as reserved
    function mode_is_reserved;
        input [3:0] m;
        begin
            mode_is_reserved = !(mode_is_mii(m) || m == `SLC_MODE_NAND ||
                                 m == `SLC_MODE_PDOWN);
        end
    endfunction

    // Straps are caught on the first edge after release. Catching them
    // from the reset branch itself would load port values under reset.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            captured   <= 1'b0;
            addr_lat   <= 3'h0;
            bcast_lat  <= 1'b0;
            mode_lat   <= 4'h0;
            refclk_lat <= 1'b0;
            lamp_lat   <= 1'b0;
        end else if (!captured) begin
            captured   <= 1'b1;
            addr_lat   <= mgmt_addr_strap;
            bcast_lat  <= broadcast_addr_strap;
            mode_lat   <= mode_strap;
            refclk_lat <= refclk_out_strap;
            lamp_lat   <= lamp_style_strap;
        end
        // Nothing reloads until the next reset
    end

    // Management address match
    always @* begin
        hit_own  = addr_match(mgmt_req_addr, own_addr);
        hit_zero = addr_match(mgmt_req_addr, 5'h00) & ctrl[`SLC_CT_ADDR0_EN];
    end

    // Event sources and sticky status; a set in the clear cycle wins
    always @* begin
        events = {`SLC_EV_W{1'b0}};
        events[`SLC_EV_WAKE]  = captured & wol_event;
        events[`SLC_EV_ADDR0] = captured & mgmt_req_valid & hit_zero & ~hit_own;
        next_status = status;
        if (reg_wr && reg_addr == `SLC_REG_CLEAR) begin
            next_status = status & ~reg_wdata[`SLC_EV_W-1:0];
        end
        next_status = next_status | events;
    end

    // Control defaults come from the straps at capture
    always @* begin
        next_ctrl   = ctrl;
        next_enable = enable;
        if (!captured) begin
            // A write on the capture edge is lost to the defaults load
            next_ctrl                    = `SLC_CTRL_RST;
            next_ctrl[`SLC_CT_ADDR0_EN]  = ~broadcast_addr_strap;
            next_ctrl[`SLC_CT_REFCLK_EN] = refclk_out_strap;
            next_ctrl[`SLC_CT_ROUTE_A]   = (mode_strap == `SLC_MODE_MII_W1);
            next_ctrl[`SLC_CT_ROUTE_B]   = (mode_strap == `SLC_MODE_MII_W2);
        end else if (reg_wr && reg_addr == `SLC_REG_CTRL) begin
            next_ctrl = reg_wdata[`SLC_CTRL_W-1:0];
        end else if (reg_wr && reg_addr == `SLC_REG_ENABLE) begin
            next_enable = reg_wdata[`SLC_EV_W-1:0];
        end
    end

    // Control, enable and sticky status registers
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl   <= `SLC_CTRL_RST;
            enable <= `SLC_EV_RST;
            status <= `SLC_EV_RST;
        end else begin
            ctrl   <= next_ctrl;
            enable <= next_enable;
            status <= next_status;
        end
    end

    // Read mux; unmapped and write-only offsets read zero
    always @* begin
        next_rdata = 16'h0000;
        if (reg_addr == `SLC_REG_STRAP) begin
            next_rdata[`SLC_ST_ADDR_LSB+4:`SLC_ST_ADDR_LSB] = own_addr;
            next_rdata[`SLC_ST_MODE_LSB+3:`SLC_ST_MODE_LSB] = mode_lat;
            next_rdata[`SLC_ST_BCAST]  = bcast_lat;
            next_rdata[`SLC_ST_REFCLK] = refclk_lat;
            next_rdata[`SLC_ST_LAMP]   = lamp_lat;
            next_rdata[`SLC_ST_VALID]  = captured;
        end else if (reg_addr == `SLC_REG_CTRL) begin
            next_rdata[`SLC_CTRL_W-1:0] = ctrl;
        end else if (reg_addr == `SLC_REG_STATUS) begin
            next_rdata[`SLC_EV_W-1:0] = status;
        end else if (reg_addr == `SLC_REG_ENABLE) begin
            next_rdata[`SLC_EV_W-1:0] = enable;
        end
    end

    // Pin steering
    always @* begin
        wake_a  = ctrl[`SLC_CT_ROUTE_A] & status[`SLC_EV_WAKE];
        wake_b  = ctrl[`SLC_CT_ROUTE_B] & status[`SLC_EV_WAKE];
        clk_src = ctrl[`SLC_CT_REFCLK_RX] ? refclk_rx : refclk_local;
    end

    // Next pin levels. Pin A doubles as wake pin while route A is set, low while
    // a wake is pending; its lamp level is lost for as long as route A is set.
    always @* begin
        next_lamp_a = ctrl[`SLC_CT_ROUTE_A] ? ~wake_a : lamp_a_in;
        next_lamp_b = lamp_b_in;
        next_wake_n = ~wake_b;
        // Power-down also silences the clock output
        next_refclk = ctrl[`SLC_CT_REFCLK_EN] & ~mode_power_down & clk_src;
    end

    // Next mode decode; all quiet until the straps are in
    always @* begin
        next_mii      = captured & mode_is_mii(mode_lat);
        next_nand     = captured & (mode_lat == `SLC_MODE_NAND);
        next_pdown    = captured & (mode_lat == `SLC_MODE_PDOWN);
        next_reserved = captured & mode_is_reserved(mode_lat);
    end

    // Read data and management hit, both one-cycle pulses
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata     <= 16'h0000;
            mgmt_addr_hit <= 1'b0;
        end else begin
            reg_rdata     <= reg_rd ? next_rdata : 16'h0000;
            mgmt_addr_hit <= captured & mgmt_req_valid & (hit_own | hit_zero);
        end
    end

    // Pin registers. The clock pin is a resampled copy of the selected
    // source; a real part would gate it in a clock cell.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lamp_out_a     <= 1'b0;
            lamp_out_b     <= 1'b0;
            wake_event_n   <= 1'b1;
            refclk_out_pin <= 1'b0;
        end else begin
            lamp_out_a     <= next_lamp_a;
            lamp_out_b     <= next_lamp_b;
            wake_event_n   <= next_wake_n;
            refclk_out_pin <= next_refclk;
        end
    end

    // Latched configuration towards the transceiver
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mgmt_addr       <= 5'h00;
            op_mode         <= 4'h0;
            lamp_individual <= 1'b0;
            straps_valid    <= 1'b0;
        end else begin
            mgmt_addr       <= own_addr;
            op_mode         <= mode_lat;
            lamp_individual <= lamp_lat;
            straps_valid    <= captured;
        end
    end

    // Mode decode levels
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mode_mii        <= 1'b0;
            mode_nand_tree  <= 1'b0;
            mode_power_down <= 1'b0;
            mode_reserved   <= 1'b0;
        end else begin
            mode_mii        <= next_mii;
            mode_nand_tree  <= next_nand;
            mode_power_down <= next_pdown;
            mode_reserved   <= next_reserved;
        end
    end

    // Interrupt level; next status so irq rises with the status bit
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_status & enable);
        end
    end

endmodule
`default_nettype wire

// >>> design/slc_map.vh
// Constants of the strap latch and configuration block:
// register offsets, field positions, reset values and mode codes.
// Assumes inclusion by its bare name from the design files.
`ifndef SLC_MAP_VH
`define SLC_MAP_VH

// Register port widths
`define SLC_ADDR_W          4
`define SLC_DATA_W          16

// Register offsets
`define SLC_REG_STRAP       4'h0
`define SLC_REG_CTRL        4'h1
`define SLC_REG_STATUS      4'h2
`define SLC_REG_CLEAR       4'h3
`define SLC_REG_ENABLE      4'h4

// Strap register fields
`define SLC_ST_ADDR_LSB     0
`define SLC_ST_MODE_LSB     5
`define SLC_ST_BCAST        9
`define SLC_ST_REFCLK       10
`define SLC_ST_LAMP         11
`define SLC_ST_VALID        15

// Control register fields
`define SLC_CT_ADDR0_EN     0
`define SLC_CT_REFCLK_RX    1
`define SLC_CT_ROUTE_A      2
`define SLC_CT_ROUTE_B      3
`define SLC_CT_REFCLK_EN    4
`define SLC_CTRL_W          5

// Event bits of status, clear and enable
`define SLC_EV_WAKE         0
`define SLC_EV_ADDR0        1
`define SLC_EV_W            2

// Reset values and fixed upper management address bits
`define SLC_CTRL_RST        5'h00
`define SLC_EV_RST          2'h0
`define SLC_ADDR_HI         2'h0

// Device mode codes
`define SLC_MODE_MII        4'h1
`define SLC_MODE_NAND       4'h4
`define SLC_MODE_PDOWN      4'h7
`define SLC_MODE_MII_W1     4'h9
`define SLC_MODE_MII_W2     4'hb

`endif

// >>> verification/slc_strap_latch_assertions.sv
// Port checker of the strap latch: decode, address match and hold.
// Assumes it is bound to every instance of the strap latch.
`timescale 1ns/100ps
`default_nettype none
module slc_strap_latch_assertions (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       nrst,
    // Watched ports
    input wire logic       mgmt_req_valid,
    input wire logic [4:0] mgmt_req_addr,
    input wire logic       mgmt_addr_hit,
    input wire logic [4:0] mgmt_addr,
    input wire logic [3:0] op_mode,
    input wire logic       mode_mii,
    input wire logic       mode_nand_tree,
    input wire logic       mode_power_down,
    input wire logic       straps_valid,
    input wire logic       refclk_out_pin,
    input wire logic       irq,
    input wire logic       wake_event_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    AST_ADDR_HI: assert property (straps_valid |-> mgmt_addr[4:3] == 2'h0)
        else $error("address upper bits not zero");
    AST_HOLD: assert property (straps_valid && $past(straps_valid) |-> $stable(mgmt_addr) && $stable(op_mode))
        else $error("latched straps changed");
    AST_NAND: assert property (straps_valid |-> mode_nand_tree == (op_mode == 4'h4))
        else $error("test mode decode wrong");
    AST_PDOWN: assert property (straps_valid |-> mode_power_down == (op_mode == 4'h7))
        else $error("power-down decode wrong");
    AST_MII: assert property (straps_valid |-> mode_mii == (op_mode inside {4'h1, 4'h9, 4'hb}))
        else $error("interface mode decode wrong");
    AST_HIT: assert property (mgmt_req_valid && straps_valid && mgmt_req_addr == mgmt_addr |=> mgmt_addr_hit)
        else $error("own address not answered");
    AST_MISS: assert property (mgmt_req_valid && mgmt_req_addr != mgmt_addr && mgmt_req_addr != 5'h0
        |=> !mgmt_addr_hit)
        else $error("foreign address answered");
    AST_PD_CLK: assert property (mode_power_down && $past(mode_power_down) |-> !refclk_out_pin)
        else $error("clock out in power-down");
    COV_HIT: cover property (mgmt_req_valid ##1 mgmt_addr_hit);
    COV_IRQ: cover property ($rose(irq));
    COV_WAKE: cover property ($fell(wake_event_n));
endmodule
bind slc_strap_latch slc_strap_latch_assertions u_chk (.core_clk, .nrst, .mgmt_req_valid, .mgmt_req_addr,
    .mgmt_addr_hit, .mgmt_addr, .op_mode, .mode_mii, .mode_nand_tree, .mode_power_down, .straps_valid,
    .refclk_out_pin, .irq, .wake_event_n);
`default_nettype wire

// >>> verification/slc_board_pulls.sv
// Board pull resistors on the strap pins.
// Assumes disturb is raised only after straps are captured.
`timescale 1ns/100ps
`default_nettype none
module slc_board_pulls (
    // Wanted levels {lamp, refclk, broadcast, mode, address}
    input  wire logic [9:0] cfg,
    input  wire logic       disturb,
    // Strap pins
    output wire logic [2:0] mgmt_addr_strap,
    output wire logic       broadcast_addr_strap,
    output wire logic [3:0] mode_strap,
    output wire logic       refclk_out_strap,
    output wire logic       lamp_style_strap
);
    // Late noise flips every strap, so a resample would show
    assign {lamp_style_strap, refclk_out_strap, broadcast_addr_strap, mode_strap, mgmt_addr_strap}
        = cfg ^ {10{disturb}};
endmodule
`default_nettype wire

// >>> verification/slc_strap_latch_bench.sv
// Bench of the strap latch: every mode code with random straps,
// then wake routing, interrupt masking and clock source select.
// Assumes the board pull model drives the straps.
`timescale 1ns/100ps
`default_nettype none
`include "slc_map.vh"
module slc_strap_latch_bench;
    logic core_clk = 1'b0, nrst = 1'b0, disturb = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic mgmt_req_valid = 1'b0, wol_event = 1'b0, refclk_local = 1'b1, refclk_rx = 1'b0;
    logic [9:0] cfg = 10'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0;
    logic [4:0] mgmt_req_addr = 5'h0;
    logic [2:0] mgmt_addr_strap;
    logic [3:0] mode_strap, op_mode;
    logic broadcast_addr_strap, refclk_out_strap, lamp_style_strap, mgmt_addr_hit, lamp_out_a, wake_event_n;
    logic refclk_out_pin, lamp_individual, mode_mii, mode_nand_tree, mode_power_down, mode_reserved, irq;
    logic [15:0] reg_rdata;
    logic [4:0] mgmt_addr;
    logic lamp_a_in = 1'b1, lamp_b_in = 1'b0, lamp_out_b, straps_valid;
    logic [9:0] r;
    int failures = 0;
    int compares = 0;
    always #2.5 core_clk = ~core_clk;
    slc_board_pulls u_pulls (.cfg, .disturb, .mgmt_addr_strap, .broadcast_addr_strap, .mode_strap,
        .refclk_out_strap, .lamp_style_strap);
    slc_strap_latch u_dut (.core_clk, .nrst, .mgmt_addr_strap, .broadcast_addr_strap, .mode_strap,
        .refclk_out_strap, .lamp_style_strap, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .mgmt_req_valid, .mgmt_req_addr, .mgmt_addr_hit, .wol_event, .lamp_a_in, .lamp_b_in,
        .refclk_local, .refclk_rx, .lamp_out_a, .lamp_out_b, .wake_event_n, .refclk_out_pin, .mgmt_addr,
        .op_mode, .lamp_individual, .mode_mii, .mode_nand_tree, .mode_power_down, .mode_reserved,
        .straps_valid, .irq);
    function automatic logic [3:0] dec(input logic [3:0] m);
        logic x;
        x = m == 4'h1 || m == 4'h9 || m == 4'hb;
        return {x, m == 4'h4, m == 4'h7, !(x || m == 4'h4 || m == 4'h7)};
    endfunction
    task automatic conclude;
        if (failures == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tk;
        @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        tk;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
        tk;
    endtask
    task automatic mreq(input logic [4:0] a, input logic e);
        mgmt_req_valid <= 1'b1;
        mgmt_req_addr <= a;
        @(posedge core_clk);
        mgmt_req_valid <= 1'b0;
        #1 chk(16'(mgmt_addr_hit), 16'(e));
        tk;
    endtask
    task automatic release_rst;
        nrst <= 1'b1;
        tk;
        tk;
    endtask
    initial begin
        #50000;
        failures++;
        conclude;
    end
    initial begin
        void'($urandom(32'h34ef));
        repeat (10) tk;
        for (int i = 0; i < 16; i++) begin
            r = 10'($urandom);
            r[6:3] = 4'(i);
            if (i == 0) r[2:0] = 3'h0;
            if (i == 15) r[2:0] = 3'h7;
            cfg <= r;
            chk(16'({straps_valid, wake_event_n}), 16'h1);
            release_rst;
            chk(16'(straps_valid), 16'h1);
            chk(16'(mgmt_addr), 16'(cfg[2:0]));
            chk(16'(op_mode), 16'(i));
            chk(16'({mode_mii, mode_nand_tree, mode_power_down, mode_reserved}), 16'(dec(cfg[6:3])));
            chk(16'(lamp_individual), 16'(cfg[9]));
            rd(`SLC_REG_STRAP, {4'h8, cfg[9:7], cfg[6:3], 2'h0, cfg[2:0]});
            rd(`SLC_REG_CTRL, 16'({cfg[8], i == 11, i == 9, 1'b0, !cfg[7]}));
            disturb <= 1'b1;
            mreq({2'h0, cfg[2:0]}, 1'b1);
            mreq(5'h0, !cfg[7] || cfg[2:0] == 3'h0);
            mreq({2'h1, cfg[2:0]}, 1'b0);
            chk(16'(mgmt_addr), 16'(cfg[2:0]));
            chk(16'(refclk_out_pin), 16'(cfg[8] && i != 7));
            disturb <= 1'b0;
            nrst <= 1'b0;
            tk;
        end
        cfg <= 10'h10d;
        release_rst;
        wr(`SLC_REG_CTRL, 16'h1d);
        wol_event <= 1'b1;
        tk;
        wol_event <= 1'b0;
        tk;
        chk(16'({irq, wake_event_n, lamp_out_a}), 16'h0);
        rd(`SLC_REG_STATUS, 16'h1);
        wr(`SLC_REG_ENABLE, 16'h1);
        wr(`SLC_REG_CTRL, 16'h19);
        tk;
        chk(16'({irq, wake_event_n, lamp_out_a}), 16'h5);
        wr(`SLC_REG_CLEAR, 16'h1);
        tk;
        chk(16'({irq, wake_event_n}), 16'h1);
        mreq(5'h0, 1'b1);
        lamp_b_in <= 1'b1;
        rd(`SLC_REG_STATUS, 16'h2);
        chk(16'({irq, lamp_out_b}), 16'h1);
        rd(4'h9, 16'h0);
        refclk_local <= 1'b0;
        refclk_rx <= 1'b1;
        wr(`SLC_REG_CTRL, 16'h12);
        tk;
        chk(16'(refclk_out_pin), 16'h1);
        conclude;
    end
endmodule
`default_nettype wire
